// [include/cds_pkg.sv]
// constants and types for the chopper decay sequencer
package cds_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int BLANK_NS = 1000;      // forced charge after each oscillator rise
   localparam int TAIL_FAST_NS = 1000;  // mixed decay: fast decay at period end
   // least time rounds up
   localparam int BLANK_CYC_INT = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // longest time rounds down
   localparam int TAIL_CYC_INT = TAIL_FAST_NS / CLK_PERIOD_NS;

   localparam int CNT_W = 16;           // elapsed-cycle counter width
   localparam int PHASES = 2;
   localparam int SYNC_W = 5;           // osc, select high, select low, two comparators

   localparam logic [CNT_W-1:0] BLANK_CYC = CNT_W'(BLANK_CYC_INT);
   localparam logic [CNT_W-1:0] TAIL_CYC = CNT_W'(TAIL_CYC_INT);
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

   // per-phase drive state, one-hot
   typedef enum logic [2:0] {
      CDS_CHARGE = 3'h1,
      CDS_SLOW = 3'h2,
      CDS_FAST = 3'h4
   } cds_drive_t;

   // decay method chosen by the decay-select input level
   typedef enum logic [1:0] {
      CDS_MODE_SLOW = 2'h0,
      CDS_MODE_FAST = 2'h1,
      CDS_MODE_MIXED = 2'h2
   } cds_mode_t;

   localparam cds_drive_t DRIVE_RST = CDS_FAST;
   localparam cds_mode_t MODE_RST = CDS_MODE_MIXED;
endpackage

// [include/cds_sync_if.sv]
// synchronised pin levels and oscillator edge passed to the sequencer
`timescale 1ns/10ps
interface cds_sync_if;
   import cds_pkg::*;
   logic osc_rise;
   logic sel_high;
   logic sel_low;
   logic [PHASES-1:0] coil_ge_set;

   modport src (
      output osc_rise,
      output sel_high,
      output sel_low,
      output coil_ge_set
   );
   modport dst (
      input osc_rise,
      input sel_high,
      input sel_low,
      input coil_ge_set
   );
endinterface

// [rtl/cds_input_sync.sv]
// two-flop synchronisers for the analog-side levels and oscillator edge detect
`timescale 1ns/10ps
module cds_input_sync
   import cds_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic chop_osc_i,
   input wire logic decay_select_high_i,
   input wire logic decay_select_low_i,
   input wire logic [PHASES-1:0] coil_ge_set_i,
   cds_sync_if.src sync
);
   logic [SYNC_W-1:0] meta_q, meta_d;
   logic [SYNC_W-1:0] stab_q, stab_d;
   logic osc_last_q, osc_last_d;

   // next values: first stage only feeds second stage
   always_comb begin
      meta_d = {coil_ge_set_i, decay_select_low_i, decay_select_high_i, chop_osc_i};
      stab_d = meta_q;
      osc_last_d = stab_q[0];
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= '0;
         stab_q <= '0;
         osc_last_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         stab_q <= stab_d;
         osc_last_q <= osc_last_d;
      end
   end

   // edge taken from the stable stage only
   assign sync.osc_rise = stab_q[0] & ~osc_last_q;
   assign sync.sel_high = stab_q[1];
   assign sync.sel_low = stab_q[2];
   assign sync.coil_ge_set = stab_q[4:3];
endmodule

// [rtl/cds_sequencer.sv]
// chopper decay sequencer: per-phase charge / slow / fast drive selection
//
// Overview of operation
// - select above 3.5 V: slow decay each period
// - select below 0.8 V: fast decay each period
// - oscillator rising edge forces charge state
// - hold charge 1 us blanking, ignore comparator
// - slow mode: charge until current reached, slow
// - fast mode: charge until current reached, fast
// - mixed: sample comparison during blanking
// - mixed, seen: charge, slow, fast last 1us
// - mixed, not seen: fast decay to end
`timescale 1ns/10ps
module cds_sequencer
   import cds_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic chop_osc_i,
   input wire logic decay_select_high_i,
   input wire logic decay_select_low_i,
   input wire logic [PHASES-1:0] coil_ge_set_i,
   output logic [2:0] phase_a_drive_o,
   output logic [2:0] phase_b_drive_o,
   output logic [1:0] decay_mode_o,
   output logic blanking_o
);
   cds_sync_if sync_bus ();

   // every pin-side level passes the two-flop stage in here before any logic reads it
   cds_input_sync u_sync (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .chop_osc_i(chop_osc_i),
      .decay_select_high_i(decay_select_high_i),
      .decay_select_low_i(decay_select_low_i),
      .coil_ge_set_i(coil_ge_set_i),
      .sync(sync_bus.src)
   );

   // local names for the synchronised inputs, all on the core clock now
   logic period_start;
   logic sel_high_now;
   logic sel_low_now;
   logic [PHASES-1:0] cmp_now;

   assign period_start = sync_bus.osc_rise;
   assign sel_high_now = sync_bus.sel_high;
   assign sel_low_now = sync_bus.sel_low;
   assign cmp_now = sync_bus.coil_ge_set;

   // true when the period end is at most the tail time away
   // one extra bit on the sum so a long period cannot wrap and miss its tail
   function automatic logic in_tail(input logic [CNT_W-1:0] elapsed,
                                    input logic [CNT_W-1:0] last_len,
                                    input logic len_valid);
      logic [CNT_W:0] reach;
      reach = {1'b0, elapsed} + {1'b0, TAIL_CYC};
      in_tail = len_valid && (reach >= {1'b0, last_len});
   endfunction

   // decode the two threshold levels into a decay method
   // both levels high cannot happen on a sane pin; slow wins as the gentler choice
   function automatic cds_mode_t decode_mode(input logic sel_high, input logic sel_low);
      if (sel_high) begin
         decode_mode = CDS_MODE_SLOW;
      end else if (sel_low) begin
         decode_mode = CDS_MODE_FAST;
      end else begin
         decode_mode = CDS_MODE_MIXED;
      end
   endfunction

   // ---------------- period timing ----------------
   logic [CNT_W-1:0] elapsed_q, elapsed_d;
   logic [CNT_W-1:0] last_len_q, last_len_d;
   logic len_valid_q, len_valid_d;
   logic blank_q, blank_d;
   cds_mode_t mode_q, mode_d;

   // elapsed cycles since the last rise; the previous period length predicts
   // where the current period ends, since the oscillator gives no advance warning
   always_comb begin
      elapsed_d = elapsed_q;
      last_len_d = last_len_q;
      len_valid_d = len_valid_q;
      blank_d = blank_q;
      mode_d = mode_q;
      if (period_start) begin
         // a rise always restarts the count, even one that lands mid-blanking
         elapsed_d = CNT_ONE;
         blank_d = 1'b1;

         // the method is latched once per period; later select changes wait
         mode_d = decode_mode(sel_high_now, sel_low_now);

         // remember how long the period just ended was
         if (elapsed_q != CNT_ZERO) begin
            last_len_d = elapsed_q;
            len_valid_d = 1'b1;
         end
      end else begin
         // zero means no period seen yet, max means stalled: both hold still
         if (elapsed_q != CNT_ZERO && elapsed_q != CNT_MAX) begin
            elapsed_d = elapsed_q + CNT_ONE;
         end
         // blanking spans exactly the blanking count of core cycles
         if (elapsed_q >= BLANK_CYC) begin
            blank_d = 1'b0;
         end
         // a stalled oscillator drops the prediction rather than trusting it
         if (elapsed_q == CNT_MAX) begin
            len_valid_d = 1'b0;
         end
      end
   end

   // period timing registers
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         elapsed_q <= CNT_ZERO;
         last_len_q <= CNT_ZERO;
         len_valid_q <= 1'b0;
         blank_q <= 1'b0;
         mode_q <= MODE_RST;
      end else begin
         elapsed_q <= elapsed_d;
         last_len_q <= last_len_d;
         len_valid_q <= len_valid_d;
         blank_q <= blank_d;
         mode_q <= mode_d;
      end
   end

   // ---------------- per-phase drive state ----------------
   cds_drive_t drive_q [PHASES], drive_d [PHASES];
   logic [PHASES-1:0] seen_q, seen_d;
   logic tail_now;

   // tail is a prediction from the last period; the first period has none
   assign tail_now = in_tail(elapsed_q, last_len_q, len_valid_q);

   // three-state machine per phase; the blanking flag gates the comparator
   always_comb begin
      for (int p = 0; p < PHASES; p++) begin
         drive_d[p] = drive_q[p];
         seen_d[p] = seen_q[p];
         if (period_start) begin
            // every period opens in charge, whatever the method
            drive_d[p] = CDS_CHARGE;
            seen_d[p] = 1'b0;
         end else if (blank_q) begin
            // charge is held whatever the comparator says
            drive_d[p] = CDS_CHARGE;
            // only mixed decay uses this, but sampling always keeps it simple
            if (cmp_now[p]) begin
               seen_d[p] = 1'b1;
            end
         end else begin
            case (drive_q[p])
               CDS_CHARGE: begin
                  if (mode_q == CDS_MODE_MIXED && !seen_q[p]) begin
                     // no match in blanking: current stayed below target, drain it
                     drive_d[p] = CDS_FAST;
                  end else if (cmp_now[p]) begin
                     case (mode_q)
                        CDS_MODE_SLOW: begin
                           drive_d[p] = CDS_SLOW;
                        end
                        CDS_MODE_FAST: begin
                           drive_d[p] = CDS_FAST;
                        end
                        default: begin
                           // tail already reached: skip slow decay altogether
                           if (tail_now) begin
                              drive_d[p] = CDS_FAST;
                           end else begin
                              drive_d[p] = CDS_SLOW;
                           end
                        end
                     endcase
                  end
               end
               CDS_SLOW: begin
                  // only mixed decay leaves slow decay before the period ends
                  if (mode_q == CDS_MODE_MIXED && tail_now) begin
                     drive_d[p] = CDS_FAST;
                  end
               end
               CDS_FAST: begin
                  // fast decay is left only by the next oscillator rise
                  drive_d[p] = CDS_FAST;
               end
               default: begin
                  // an illegal code falls back to the safe reset drive
                  drive_d[p] = DRIVE_RST;
               end
            endcase
         end
      end
   end


   // per-phase drive registers; reset leaves the coils draining
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int p = 0; p < PHASES; p++) begin
            drive_q[p] <= DRIVE_RST;
         end
         seen_q <= '0;
      end else begin
         for (int p = 0; p < PHASES; p++) begin
            drive_q[p] <= drive_d[p];
         end
         seen_q <= seen_d;
      end
   end


   // outputs straight from flops, no logic between register and pin
   assign phase_a_drive_o = drive_q[0];
   assign phase_b_drive_o = drive_q[1];
   assign decay_mode_o = mode_q;
   assign blanking_o = blank_q;
endmodule

// [dv/cds_sequencer_assertions.sv]
// port-level checker for the chopper decay sequencer
`timescale 1ns/10ps
module cds_sequencer_chk
   import cds_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic chop_osc_i,
   input wire logic decay_select_high_i,
   input wire logic decay_select_low_i,
   input wire logic [PHASES-1:0] coil_ge_set_i,
   input wire logic [2:0] phase_a_drive_o,
   input wire logic [2:0] phase_b_drive_o,
   input wire logic [1:0] decay_mode_o,
   input wire logic blanking_o
);
   logic seen_b_q;
   logic seen_b_d;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   // phase b comparator seen while blanking; cleared outside so each period starts fresh
   always_comb begin
      seen_b_d = blanking_o ? (seen_b_q | coil_ge_set_i[1]) : 1'b0;
   end
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) seen_b_q <= 1'b0;
      else seen_b_q <= seen_b_d;
   end
   sequence charge_both;
      phase_a_drive_o == CDS_CHARGE && phase_b_drive_o == CDS_CHARGE;
   endsequence
   sequence blank_window;
      ##99 blanking_o ##1 !blanking_o;
   endsequence
   a_rise_charge: assert property ($rose(chop_osc_i) |-> ##3 (charge_both and blanking_o))
      else $error("no charge after oscillator rise");
   a_blank_len: assert property ($rose(blanking_o) |-> blank_window)
      else $error("blanking length wrong");
   a_blank_charge: assert property (blanking_o |-> charge_both)
      else $error("drive left charge during blanking");
   a_sel_slow: assert property ($rose(chop_osc_i) && decay_select_high_i |-> ##3 decay_mode_o == CDS_MODE_SLOW)
      else $error("slow method not latched");
   a_sel_fast: assert property ($rose(chop_osc_i) && decay_select_low_i && !decay_select_high_i
      |-> ##3 decay_mode_o == CDS_MODE_FAST)
      else $error("fast method not latched");
   a_sel_mixed: assert property ($rose(chop_osc_i) && !decay_select_low_i && !decay_select_high_i
      |-> ##3 decay_mode_o == CDS_MODE_MIXED)
      else $error("mixed method not latched");
   a_slow_nofast: assert property (decay_mode_o == CDS_MODE_SLOW |-> phase_a_drive_o != CDS_FAST)
      else $error("fast decay in slow method");
   a_fast_noslow: assert property (decay_mode_o == CDS_MODE_FAST |-> phase_b_drive_o != CDS_SLOW)
      else $error("slow decay in fast method");
   a_cmp_trip: assert property (decay_mode_o == CDS_MODE_SLOW && phase_a_drive_o == CDS_CHARGE && !blanking_o
      && coil_ge_set_i[0] |-> ##[1:3] phase_a_drive_o == CDS_SLOW)
      else $error("charge not ended at set current");
   a_mixed_unseen: assert property ($fell(blanking_o) && decay_mode_o == CDS_MODE_MIXED && !seen_b_q
      |-> ##[0:2] phase_b_drive_o == CDS_FAST)
      else $error("mixed unseen not fast");
endmodule
bind cds_sequencer cds_sequencer_chk u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
   .chop_osc_i(chop_osc_i), .decay_select_high_i(decay_select_high_i), .decay_select_low_i(decay_select_low_i),
   .coil_ge_set_i(coil_ge_set_i), .phase_a_drive_o(phase_a_drive_o), .phase_b_drive_o(phase_b_drive_o),
   .decay_mode_o(decay_mode_o), .blanking_o(blanking_o));

// [dv/cds_coil_model.sv]
// behavioural winding with current comparator for one phase
`timescale 1ns/10ps
module cds_coil_model
   import cds_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic [2:0] drive_i,
   input wire logic [9:0] set_lvl_i,
   output logic ge_o
);
   int lvl = 0;
   // charge ramps up, slow decay bleeds, fast decay drains twice as hard
   always_ff @(posedge core_clk_i) begin
      if (drive_i == CDS_CHARGE) lvl <= lvl + 1;
      else if (drive_i == CDS_FAST) lvl <= (lvl > 1) ? lvl - 2 : 0;
      else if (lvl > 0) lvl <= lvl - 1;
   end
   assign ge_o = (lvl >= int'(set_lvl_i));
endmodule

// [dv/cds_sequencer_tb.sv]
// self-checking bench for the chopper decay sequencer
`timescale 1ns/10ps
module cds_sequencer_tb;
   import cds_pkg::*;
   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic chop_osc_i = 1'b0;
   logic sel_hi = 1'b0;
   logic sel_lo = 1'b0;
   logic [PHASES-1:0] ge;
   logic [9:0] set_a = 10'h000;
   logic [9:0] set_b = 10'h000;
   logic [2:0] drv_a;
   logic [2:0] drv_b;
   logic [1:0] mode;
   logic blank;
   int n_mismatch = 0;
   int compares = 0;
   cds_sequencer dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .chop_osc_i(chop_osc_i),
      .decay_select_high_i(sel_hi), .decay_select_low_i(sel_lo), .coil_ge_set_i(ge),
      .phase_a_drive_o(drv_a), .phase_b_drive_o(drv_b), .decay_mode_o(mode), .blanking_o(blank));
   cds_coil_model coil_a (.core_clk_i(core_clk_i), .drive_i(drv_a), .set_lvl_i(set_a), .ge_o(ge[0]));
   cds_coil_model coil_b (.core_clk_i(core_clk_i), .drive_i(drv_b), .set_lvl_i(set_b), .ge_o(ge[1]));
   initial begin
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one 400-cycle oscillator period; drives sampled early, mid and just before the end
   task automatic period(input logic [2:0] a1, b1, a2, b2, input logic [1:0] md);
      @(posedge core_clk_i) chop_osc_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      #1;
      chk(drv_a, CDS_CHARGE);
      chk(drv_b, CDS_CHARGE);
      chk({1'b0, mode}, {1'b0, md});
      chk({2'h0, blank}, 3'h1);
      repeat (46) @(posedge core_clk_i);
      #1;
      chk(drv_b, CDS_CHARGE);
      repeat (150) @(posedge core_clk_i) chop_osc_i <= 1'b0;
      #1;
      chk(drv_a, a1);
      chk(drv_b, b1);
      repeat (196) @(posedge core_clk_i);
      #1;
      chk(drv_a, a2);
      chk(drv_b, b2);
      repeat (3) @(posedge core_clk_i);
   endtask
   task automatic test_slow();
      @(posedge core_clk_i) {sel_hi, sel_lo, set_a, set_b} <= {2'b10, 10'd150, 10'd20};
      repeat (2) period(CDS_SLOW, CDS_SLOW, CDS_SLOW, CDS_SLOW, CDS_MODE_SLOW);
   endtask
   task automatic test_fast();
      @(posedge core_clk_i) {sel_hi, sel_lo} <= 2'b01;
      repeat (2) period(CDS_FAST, CDS_FAST, CDS_FAST, CDS_FAST, CDS_MODE_FAST);
   endtask
   // phase a sees its set current in blanking, phase b never does
   task automatic test_mixed();
      @(posedge core_clk_i) {sel_hi, sel_lo, set_a, set_b} <= {2'b00, 10'd20, 10'd1000};
      repeat (2) period(CDS_SLOW, CDS_FAST, CDS_FAST, CDS_FAST, CDS_MODE_MIXED);
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // watchdog well past the roughly 2400 cycles the tests need
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      test_slow();
      test_fast();
      test_mixed();
      report_and_stop();
   end
endmodule
